// >>> src/arx_pkg.sv
// Constants and types shared by the ARINC 429 receive logic
package arx_pkg;
  // Sample clock derived from the 25 MHz reference
  localparam int REF_CLK_PERIOD_NS   = 40;
  localparam int ARINC_CLK_PERIOD_NS = 1000;
  localparam int CLKS_PER_ARINC      = ARINC_CLK_PERIOD_NS / REF_CLK_PERIOD_NS;
  localparam int LOW_SPEED_RATIO     = 8;
  localparam logic [7:0] DIV_HI_LAST = 8'(CLKS_PER_ARINC - 1);
  localparam logic [7:0] DIV_LO_LAST = 8'(CLKS_PER_ARINC * LOW_SPEED_RATIO - 1);
  // Sampling shift registers
  localparam int SHIFT_W = 10;
  localparam int HALF_W  = 5;
  // Bit spacing in samples, word gap probing
  localparam logic [3:0] BIT_MIN_SAMPLES = 4'h8;
  localparam logic [3:0] BIT_MAX_SAMPLES = 4'hc;
  localparam logic [3:0] GAP_EVERY_LAST  = 4'h9;  // 250 clocks fast, 2000 slow: 10 samples
  localparam logic [1:0] GAP_NULLS_LAST  = 2'h2;  // Third null releases
  localparam logic [4:0] LAST_BIT_IDX    = 5'h1f;
  localparam logic [31:0] WORD_RST       = 32'h0;
  // Receive FIFO
  localparam int FIFO_DEPTH              = 32;
  localparam logic [5:0] FIFO_FULL_CNT   = 6'h20;
  localparam logic [5:0] FIFO_HALF_CNT   = 6'h10;
  localparam logic FLAG_EMPTY_RST        = 1'b1;
  // Host instructions and status layout
  localparam logic [7:0] OP_READ_WORD    = 8'h08;
  localparam logic [7:0] OP_READ_STATUS  = 8'h0a;
  localparam int ST_EMPTY_POS            = 0;
  localparam int ST_HALF_POS             = 1;
  localparam int ST_FULL_POS             = 2;
  // Response buffer
  localparam logic [1:0] SKID_FULL_CNT   = 2'h2;
  typedef enum logic [1:0] {RX_GAP, RX_IDLE, RX_WORD} arx_state_type;
endpackage

// >>> src/arx_sampler.sv
// Line state synchroniser, sampling shift registers and bit qualifier
`timescale 1ns/1ps
module arx_sampler (
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic clear_i,
  input  wire logic sample_i,
  input  wire logic line_one_i,
  input  wire logic line_zero_i,
  input  wire logic line_null_i,
  output logic      sample_o,
  output logic      bit_strobe_o,
  output logic      bit_value_o,
  output logic      gap_null_o
);
  import arx_pkg::*;
  logic [2:0]         s1_r, s2_r;
  logic [SHIFT_W-1:0] one_r, zero_r, null_r, one_nxt, zero_nxt, null_nxt;
  logic               prev_r, prev_nxt, stb_nxt, val_nxt, gap_nxt;
  logic               one_hi, zero_hi, null_hi, null_lo, data_det;

  function automatic logic run3(input logic [HALF_W-1:0] h);
    run3 = (h[4] & h[3] & h[2]) | (h[3] & h[2] & h[1]) | (h[2] & h[1] & h[0]);
  endfunction

  // Qualify runs of three: data in the upper half, null in both halves; shift all three bands each sample
  always_comb begin
    one_hi   = run3(one_r[SHIFT_W-1:HALF_W]);
    zero_hi  = run3(zero_r[SHIFT_W-1:HALF_W]);
    null_hi  = run3(null_r[SHIFT_W-1:HALF_W]);
    null_lo  = run3(null_r[HALF_W-1:0]);
    data_det = (one_hi || zero_hi) && null_lo;
    one_nxt  = one_r;
    zero_nxt = zero_r;
    null_nxt = null_r;
    prev_nxt = prev_r;
    stb_nxt  = 1'b0;
    val_nxt  = bit_value_o;
    gap_nxt  = gap_null_o;
    if (clear_i) begin
      one_nxt  = '0;
      zero_nxt = '0;
      null_nxt = '0;
      prev_nxt = 1'b0;
      gap_nxt  = 1'b0;
    end else if (sample_i) begin
      one_nxt  = {one_r[SHIFT_W-2:0], s2_r[0]};
      zero_nxt = {zero_r[SHIFT_W-2:0], s2_r[1] && !s2_r[0]};
      null_nxt = {null_r[SHIFT_W-2:0], s2_r[2] && !s2_r[1] && !s2_r[0]};
      prev_nxt = data_det;
      stb_nxt  = data_det && !prev_r;
      val_nxt  = one_hi;
      gap_nxt  = null_hi && null_lo;
    end
  end

  // Pin synchroniser and registers
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s1_r         <= '0;
      s2_r         <= '0;
      one_r        <= '0;
      zero_r       <= '0;
      null_r       <= '0;
      prev_r       <= 1'b0;
      sample_o     <= 1'b0;
      bit_strobe_o <= 1'b0;
      bit_value_o  <= 1'b0;
      gap_null_o   <= 1'b0;
    end else begin
      s1_r         <= {line_null_i, line_zero_i, line_one_i};
      s2_r         <= s1_r;
      one_r        <= one_nxt;
      zero_r       <= zero_nxt;
      null_r       <= null_nxt;
      prev_r       <= prev_nxt;
      sample_o     <= sample_i;
      bit_strobe_o <= stb_nxt;
      bit_value_o  <= val_nxt;
      gap_null_o   <= gap_nxt;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_one_band_only: assert property ($onehot0({one_r[0], zero_r[0], null_r[0]}))
    else $error("more than one band sampled high");
  a_bit_qualified: assert property (bit_strobe_o |->
    $past(null_lo) && ($past(one_hi) || $past(zero_hi)))
    else $error("bit strobe without qualified runs");
  a_gap_qualified: assert property ($rose(gap_null_o) |-> $past(null_hi) && $past(null_lo))
    else $error("gap null without runs in both halves");
endmodule // arx_sampler

// >>> src/arx_skid.sv
// Two-entry response buffer between the read path and the host
`timescale 1ns/1ps
module arx_skid (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        in_valid_i,
  input  wire logic [31:0] in_data_i,
  output logic             in_ready_o,
  output logic             out_valid_o,
  output logic [31:0]      out_data_o,
  input  wire logic        out_ready_i
);
  import arx_pkg::*;
  logic [1:0]  cnt_r, cnt_nxt;
  logic [31:0] tail_r, tail_nxt, head_nxt;
  logic        push, pop;

  // Head drives the output so a stall holds it steady
  always_comb begin
    push     = in_valid_i && in_ready_o;
    pop      = out_valid_o && out_ready_i;
    cnt_nxt  = cnt_r;
    head_nxt = out_data_o;
    tail_nxt = tail_r;
    unique case ({push, pop})
      2'b00: ;
      2'b10: begin
        if (cnt_r == 2'h0) head_nxt = in_data_i;
        else tail_nxt = in_data_i;
        cnt_nxt = cnt_r + 2'h1;
      end
      2'b01: begin
        head_nxt = tail_r;
        cnt_nxt  = cnt_r - 2'h1;
      end
      2'b11: begin
        if (cnt_r == 2'h1) begin
          head_nxt = in_data_i;
        end else begin
          head_nxt = tail_r;
          tail_nxt = in_data_i;
        end
      end
    endcase
  end

  // Entry count, data and registered handshakes
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cnt_r       <= '0;
      tail_r      <= '0;
      out_data_o  <= '0;
      out_valid_o <= 1'b0;
      in_ready_o  <= 1'b1;
    end else begin
      cnt_r       <= cnt_nxt;
      tail_r      <= tail_nxt;
      out_data_o  <= head_nxt;
      out_valid_o <= cnt_nxt != 2'h0;
      in_ready_o  <= cnt_nxt != SKID_FULL_CNT;
    end
  end
endmodule // arx_skid

// >>> src/arx_receiver.sv
// ARINC 429 receive logic: bit timing, word gap, filtering, FIFO, host reads
`timescale 1ns/1ps
module arx_receiver (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        hard_clear_input_i,
  input  wire logic        line_one_i,
  input  wire logic        line_zero_i,
  input  wire logic        line_null_i,
  input  wire logic        rx_speed_low_i,
  input  wire logic        label_order_select_i,
  input  wire logic        label_filter_enable_i,
  input  wire logic        decode_check_enable_i,
  input  wire logic        sdi10_match_value_i,
  input  wire logic        sdi9_match_value_i,
  input  wire logic        rx_parity_check_enable_i,
  input  wire logic        rx_flag_select_i,
  input  wire logic        lut_wr_i,
  input  wire logic [7:0]  lut_addr_i,
  input  wire logic        lut_data_i,
  input  wire logic        cmd_valid_i,
  input  wire logic [7:0]  cmd_opcode_i,
  output logic             cmd_ready_o,
  output logic             rsp_valid_o,
  output logic [31:0]      rsp_data_o,
  input  wire logic        rsp_ready_i,
  output logic             end_of_word_strobe_o,
  output logic             data_ready_o,
  output logic             rx_fifo_empty_flag_o,
  output logic             rx_fifo_half_flag_o,
  output logic             rx_fifo_full_flag_o,
  output logic             receive_flag_pin_o
);
  import arx_pkg::*;
  // Synchroniser, tick, word assembly, label table, FIFO and read path state
  logic                hclr_s1_r, hclr_s2_r, clr, tick_r, tick_nxt;
  logic                smp, bit_stb, bit_val, gap_null, eos_r, eos_nxt;
  logic [7:0]          div_r, div_nxt;
  arx_state_type       state_r, state_nxt;
  logic [4:0]          bit_cnt_r, bit_cnt_nxt;
  logic [3:0]          since_r, since_nxt, spacing, gap_div_r, gap_div_nxt;
  logic [1:0]          gap_cnt_r, gap_cnt_nxt;
  logic [31:0]         word_r, word_nxt, push_data;
  logic [255:0]        lut_r, lut_nxt;
  logic                label_ok, sdi_ok, push, pop;
  logic [31:0]         mem_r [FIFO_DEPTH];
  logic [31:0]         mem_nxt [FIFO_DEPTH];
  logic [4:0]          wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [5:0]          count_r, count_nxt;
  logic                empty_r, half_r, full_r, receive_flag_pin_r, dready_r;
  logic                cmd_fire, rd_word, rd_stat, skid_valid;
  logic [31:0]         head, label_rev, mapped, status_word, skid_data;

  assign clr  = hclr_s2_r;
  assign head = mem_r[rd_ptr_r];
  // Sample tick: 25 clocks fast, 200 clocks slow
  always_comb begin
    div_nxt  = div_r + 8'h01;
    tick_nxt = 1'b0;
    if (clr) begin
      div_nxt = '0;
    end else if (div_r >= (rx_speed_low_i ? DIV_LO_LAST : DIV_HI_LAST)) begin
      div_nxt  = '0;
      tick_nxt = 1'b1;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      hclr_s1_r <= 1'b0;
      hclr_s2_r <= 1'b0;
      div_r     <= '0;
      tick_r    <= 1'b0;
    end else begin
      hclr_s1_r <= hard_clear_input_i;
      hclr_s2_r <= hclr_s1_r;
      div_r     <= div_nxt;
      tick_r    <= tick_nxt;
    end
  end

  arx_sampler u_sampler (
    .ref_clk_i    (ref_clk_i),
    .rst_i        (rst_i),
    .clear_i      (clr),
    .sample_i     (tick_r),
    .line_one_i   (line_one_i),
    .line_zero_i  (line_zero_i),
    .line_null_i  (line_null_i),
    .sample_o     (smp),
    .bit_strobe_o (bit_stb),
    .bit_value_o  (bit_val),
    .gap_null_o   (gap_null)
  );
  // Word assembly, bit spacing check and word gap counter
  always_comb begin
    spacing     = since_r + 4'h1;
    state_nxt   = state_r;
    bit_cnt_nxt = bit_cnt_r;
    since_nxt   = since_r;
    gap_div_nxt = gap_div_r;
    gap_cnt_nxt = gap_cnt_r;
    word_nxt    = word_r;
    eos_nxt     = 1'b0;
    if (clr) begin
      state_nxt   = RX_GAP;
      bit_cnt_nxt = '0;
      since_nxt   = '0;
      gap_div_nxt = '0;
      gap_cnt_nxt = '0;
    end else if (smp) begin
      unique case (state_r)
        RX_GAP: begin
          gap_div_nxt = gap_div_r + 4'h1;
          if (gap_div_r == GAP_EVERY_LAST) begin
            gap_div_nxt = '0;
            if (!gap_null) begin
              gap_cnt_nxt = '0;
            end else if (gap_cnt_r == GAP_NULLS_LAST) begin
              gap_cnt_nxt = '0;
              state_nxt   = RX_IDLE;
            end else begin
              gap_cnt_nxt = gap_cnt_r + 2'h1;
            end
          end
        end
        RX_IDLE: begin
          if (bit_stb) begin
            word_nxt    = WORD_RST;
            word_nxt[0] = bit_val;
            bit_cnt_nxt = 5'h01;
            since_nxt   = '0;
            state_nxt   = RX_WORD;
          end
        end
        RX_WORD: begin
          if (bit_stb) begin
            since_nxt = '0;
            if (spacing < BIT_MIN_SAMPLES || spacing > BIT_MAX_SAMPLES) begin
              state_nxt = RX_GAP;
            end else begin
              word_nxt[bit_cnt_r] = bit_val;
              bit_cnt_nxt         = bit_cnt_r + 5'h01;
              if (bit_cnt_r == LAST_BIT_IDX) begin
                eos_nxt   = 1'b1;
                state_nxt = RX_GAP;
              end
            end
          end else if (spacing > BIT_MAX_SAMPLES) begin
            state_nxt = RX_GAP;
          end else begin
            since_nxt = spacing;
          end
        end
        default: state_nxt = RX_GAP;
      endcase
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_r   <= RX_GAP;
      bit_cnt_r <= '0;
      since_r   <= '0;
      gap_div_r <= '0;
      gap_cnt_r <= '0;
      word_r    <= WORD_RST;
      eos_r     <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      since_r   <= since_nxt;
      gap_div_r <= gap_div_nxt;
      gap_cnt_r <= gap_cnt_nxt;
      word_r    <= word_nxt;
      eos_r     <= eos_nxt;
    end
  end

  // Label table written by the host
  always_comb begin
    lut_nxt = lut_r;
    if (lut_wr_i) lut_nxt[lut_addr_i] = lut_data_i;
  end
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) lut_r <= '0;
    else lut_r <= lut_nxt;
  end

  // Acceptance filters and parity marking of the finished word
  always_comb begin
    label_ok = !label_filter_enable_i || lut_r[word_r[7:0]];
    sdi_ok   = !decode_check_enable_i ||
               (word_r[9] == sdi10_match_value_i && word_r[8] == sdi9_match_value_i);
    push     = eos_r && label_ok && sdi_ok && !clr;
    push_data = word_r;
    if (rx_parity_check_enable_i) push_data[31] = ~(^word_r);
  end

  // Label bits reversed for the default order
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_label
      assign label_rev[gi] = head[7-gi];
    end
  endgenerate
  assign label_rev[31:8] = head[31:8];

  // Host command decode and response word
  always_comb begin
    mapped      = label_order_select_i ? head : label_rev;
    cmd_fire    = cmd_valid_i && cmd_ready_o;
    rd_word     = cmd_fire && cmd_opcode_i == OP_READ_WORD;
    rd_stat     = cmd_fire && cmd_opcode_i == OP_READ_STATUS;
    pop         = rd_word && !empty_r && !clr;
    status_word = '0;
    status_word[ST_EMPTY_POS] = empty_r;
    status_word[ST_HALF_POS]  = half_r;
    status_word[ST_FULL_POS]  = full_r;
    skid_valid  = rd_word || rd_stat;
    skid_data   = rd_stat ? status_word : (empty_r ? WORD_RST : mapped);
  end

  arx_skid u_skid (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (skid_valid),
    .in_data_i   (skid_data),
    .in_ready_o  (cmd_ready_o),
    .out_valid_o (rsp_valid_o),
    .out_data_o  (rsp_data_o),
    .out_ready_i (rsp_ready_i)
  );

  // FIFO pointers, storage and flags
  always_comb begin
    mem_nxt    = mem_r;
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    count_nxt  = count_r;
    if (clr) begin
      wr_ptr_nxt = '0;
      rd_ptr_nxt = '0;
      count_nxt  = '0;
    end else begin
      if (pop) rd_ptr_nxt = rd_ptr_r + 5'h01;
      if (push) begin
        if (full_r && !pop) begin
          mem_nxt[wr_ptr_r - 5'h01] = push_data;
        end else begin
          mem_nxt[wr_ptr_r] = push_data;
          wr_ptr_nxt        = wr_ptr_r + 5'h01;
        end
      end
      if (push && !pop && !full_r) count_nxt = count_r + 6'h01;
      else if (pop && !push) count_nxt = count_r - 6'h01;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mem_r    <= '{default: '0};
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
      empty_r  <= FLAG_EMPTY_RST;
      half_r   <= 1'b0;
      full_r   <= 1'b0;
      receive_flag_pin_r  <= FLAG_EMPTY_RST;
      dready_r <= 1'b0;
    end else begin
      mem_r    <= mem_nxt;
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r  <= count_nxt;
      empty_r  <= count_nxt == '0;
      half_r   <= count_nxt >= FIFO_HALF_CNT;
      full_r   <= count_nxt == FIFO_FULL_CNT;
      receive_flag_pin_r  <= rx_flag_select_i ? (count_nxt == FIFO_FULL_CNT) : (count_nxt == '0);
      dready_r <= count_nxt != '0;
    end
  end

  assign end_of_word_strobe_o = eos_r;
  assign data_ready_o         = dready_r;
  assign rx_fifo_empty_flag_o = empty_r;
  assign rx_fifo_half_flag_o  = half_r;
  assign rx_fifo_full_flag_o  = full_r;
  assign receive_flag_pin_o   = receive_flag_pin_r;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_early_bit;
    state_r == RX_WORD && smp && bit_stb && !clr && (since_r + 4'h1) < BIT_MIN_SAMPLES;
  endsequence
  sequence s_third_null;
    state_r == RX_GAP && smp && !clr && gap_div_r == GAP_EVERY_LAST &&
    gap_null && gap_cnt_r == GAP_NULLS_LAST;
  endsequence
  a_map_order: assert property (rd_word && !empty_r && !label_order_select_i |->
    skid_data[7] == head[0] && skid_data[0] == head[7] && skid_data[31] == head[31])
    else $error("label order mapping wrong");
  a_bit_spacing: assert property (s_early_bit |=> state_r == RX_GAP)
    else $error("early bit not rejected");
  a_gap_release: assert property (s_third_null |=> state_r == RX_IDLE)
    else $error("third gap null did not enable reception");
  a_eos_after_32: assert property (eos_r |->
    $past(bit_cnt_r) == LAST_BIT_IDX && $past(state_r) == RX_WORD)
    else $error("end of word without 32 bits");
  a_label_drop: assert property (eos_r && label_filter_enable_i &&
    !lut_r[word_r[7:0]] |-> !push ##1 $stable(count_r) || $past(pop) || $past(clr))
    else $error("disabled label loaded");
  a_sdi_drop: assert property (eos_r && decode_check_enable_i &&
    word_r[9] != sdi10_match_value_i |-> !push)
    else $error("decode mismatch loaded");
  a_empty_flag: assert property (empty_r == (count_r == '0) && dready_r == !empty_r)
    else $error("empty flag disagrees with count");
  a_read_pops: assert property (pop && !push |=> count_r == $past(count_r) - 6'h01)
    else $error("read did not remove a word");
  a_full_flag: assert property (full_r == (count_r == FIFO_FULL_CNT))
    else $error("full flag disagrees with count");
  a_full_overwrite: assert property (push && full_r && !pop |=>
    full_r && $stable(wr_ptr_r) && mem_r[wr_ptr_r - 5'h01] == $past(push_data))
    else $error("overwrite of last location failed");
  a_half_flag: assert property (half_r == (count_r >= FIFO_HALF_CNT))
    else $error("half flag disagrees with count");
  a_parity_pass: assert property (push && !rx_parity_check_enable_i |->
    push_data[31] == word_r[31])
    else $error("bit 32 altered with parity off");
  a_parity_mark: assert property (push && rx_parity_check_enable_i && (^word_r) |->
    !push_data[31] && push_data[30:0] == word_r[30:0])
    else $error("odd parity word not cleared");
  a_parity_error: assert property (push && rx_parity_check_enable_i && !(^word_r) |->
    push_data[31] && push_data[30:0] == word_r[30:0])
    else $error("even parity word not marked");
  a_receive_flag_pin_select: assert property (1'b1 |=>
    receive_flag_pin_o == ($past(rx_flag_select_i) ? full_r : empty_r))
    else $error("receive flag pin wrong source");
  a_status_word: assert property (rd_stat |->
    skid_data == {29'h0, full_r, half_r, empty_r})
    else $error("status word wrong");
  a_tick_spacing: assert property (tick_r |=> (!tick_r)[*8])
    else $error("sample ticks too close");
  a_hard_clear: assert property (clr |=>
    empty_r && count_r == '0 && state_r == RX_GAP && !full_r)
    else $error("hard clear incomplete");
endmodule // arx_receiver

// >>> sim/arx_tx_model.sv
// ARINC 429 transmitter model driving the three comparator outputs
`timescale 1ns/1ps
module arx_tx_model #(parameter int HALF_CLKS = 125) (
  input  wire logic ref_clk_i,
  output logic      line_one_o,
  output logic      line_zero_o,
  output logic      line_null_o
);
  // Line rests at null between words
  initial begin
    line_one_o  = 1'b0;
    line_zero_o = 1'b0;
    line_null_o = 1'b1;
  end
  // Bit 1 first; five samples of data, five of null, then a long gap
  task automatic send(input logic [31:0] w);
    for (int i = 0; i < 32; i++) begin
      @(negedge ref_clk_i);
      line_one_o  = w[i];
      line_zero_o = ~w[i];
      line_null_o = 1'b0;
      repeat (HALF_CLKS) @(negedge ref_clk_i);
      line_one_o  = 1'b0;
      line_zero_o = 1'b0;
      line_null_o = 1'b1;
      repeat (HALF_CLKS - 1) @(negedge ref_clk_i);  // Ten samples per bit
    end
    repeat (HALF_CLKS * 8) @(negedge ref_clk_i);  // Forty null samples
  endtask
endmodule  // arx_tx_model

// >>> sim/tb_arx_receiver.sv
// Self-checking bench for the ARINC 429 receive logic
`timescale 1ns/1ps
module tb_arx_receiver;
  import arx_pkg::*;
  typedef struct {logic [31:0] w; logic [5:0] cfg; logic lut; logic load;} arx_row_type;
  logic ref_clk_i = 1'b0, rst_i = 1'b1, hard_clear_input_i = 1'b0;
  logic line_one, line_zero, line_null;
  logic label_order_select_i = 1'b1, label_filter_enable_i = 1'b0, decode_check_enable_i = 1'b0;
  logic sdi10_match_value_i = 1'b0, sdi9_match_value_i = 1'b0, rx_parity_check_enable_i = 1'b0;
  logic lut_wr_i = 1'b0, lut_data_i = 1'b0, cmd_valid_i = 1'b0, rsp_ready_i = 1'b1;
  logic rx_flag_select_i = 1'b0;
  logic [7:0] lut_addr_i = 8'h0, cmd_opcode_i = 8'h0;
  logic cmd_ready_o, rsp_valid_o, eos_o, data_ready_o, empty_o, half_o, full_o, pin_o;
  logic [31:0] rsp_data_o, d;
  int miscompares = 0, checked = 0, cycles = 0, n, eos_n = 0;
  arx_row_type rows [8] = '{'{32'h9234_5678, 6'h20, 1'b0, 1'b1}, '{32'h1234_56c1, 6'h00, 1'b0, 1'b1},
    '{32'h8000_0003, 6'h21, 1'b0, 1'b1}, '{32'h0000_0003, 6'h21, 1'b0, 1'b1},
    '{32'h0000_0201, 6'h2c, 1'b0, 1'b1}, '{32'h0000_0101, 6'h2c, 1'b0, 1'b0},
    '{32'h0000_0055, 6'h30, 1'b0, 1'b0}, '{32'h0000_00a6, 6'h30, 1'b1, 1'b1}};
  arx_tx_model u_arx_tx_model (.ref_clk_i(ref_clk_i), .line_one_o(line_one),
    .line_zero_o(line_zero), .line_null_o(line_null));
  arx_receiver u_arx_receiver (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .hard_clear_input_i(hard_clear_input_i), .line_one_i(line_one), .line_zero_i(line_zero),
    .line_null_i(line_null), .rx_speed_low_i(1'b0), .label_order_select_i(label_order_select_i),
    .label_filter_enable_i(label_filter_enable_i), .decode_check_enable_i(decode_check_enable_i),
    .sdi10_match_value_i(sdi10_match_value_i), .sdi9_match_value_i(sdi9_match_value_i),
    .rx_parity_check_enable_i(rx_parity_check_enable_i), .rx_flag_select_i(rx_flag_select_i),
    .lut_wr_i(lut_wr_i), .lut_addr_i(lut_addr_i), .lut_data_i(lut_data_i),
    .cmd_valid_i(cmd_valid_i), .cmd_opcode_i(cmd_opcode_i), .cmd_ready_o(cmd_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .rsp_ready_i(rsp_ready_i),
    .end_of_word_strobe_o(eos_o), .data_ready_o(data_ready_o), .rx_fifo_empty_flag_o(empty_o),
    .rx_fifo_half_flag_o(half_o), .rx_fifo_full_flag_o(full_o), .receive_flag_pin_o(pin_o));
  // Clock and run limit
  always #20 ref_clk_i = ~ref_clk_i;
  // End of word pulses, counted while they stand
  always @(negedge ref_clk_i) if (eos_o === 1'b1) eos_n++;
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 95000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One instruction with the response taken while it stands
  task automatic rd(input logic [7:0] op);
    cmd_valid_i = 1'b1;
    cmd_opcode_i = op;
    @(negedge ref_clk_i);
    cmd_valid_i = 1'b0;
    repeat (5) if (rsp_valid_o !== 1'b1) @(negedge ref_clk_i);
    d = rsp_data_o;
    check(rsp_valid_o, 1'b1, "response valid");
    @(negedge ref_clk_i);
  endtask
  function automatic logic [31:0] expect_rd(arx_row_type r);
    logic [31:0] e;
    e = r.w;
    if (r.cfg[0]) e[31] = ~^r.w;
    if (!r.cfg[5]) e[7:0] = {<<{r.w[7:0]}};
    return e;
  endfunction
  task automatic finish_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Reset, table rows, then stall, refusal and hard clear
  initial begin
    repeat (4) @(negedge ref_clk_i);
    rst_i = 1'b0;
    check({empty_o, half_o, full_o, pin_o}, 4'h9, "reset flags");
    rd(OP_READ_STATUS);
    check(d, 32'h1, "status");
    repeat (800) @(negedge ref_clk_i);  // Three gap nulls must pass before the first word
    $display("test reset done");
    foreach (rows[k]) begin
      {label_order_select_i, label_filter_enable_i, decode_check_enable_i,
       sdi10_match_value_i, sdi9_match_value_i, rx_parity_check_enable_i} = rows[k].cfg;
      lut_wr_i = 1'b1;
      lut_addr_i = rows[k].w[7:0];
      lut_data_i = rows[k].lut;
      @(negedge ref_clk_i);
      lut_wr_i = 1'b0;
      u_arx_tx_model.send(rows[k].w);
      check({empty_o, data_ready_o, pin_o}, {3{rows[k].load}} ^ 3'h5, "flags");
      check(eos_n, k + 1, "end of word");
      rd(OP_READ_WORD);
      check(d, rows[k].load ? expect_rd(rows[k]) : 32'h0, "word");
      check(empty_o, 1'b1, "drained");
      $display("test %0d done", k);
    end
    rsp_ready_i = 1'b0;
    cmd_valid_i = 1'b1;
    cmd_opcode_i = OP_READ_STATUS;
    repeat (4) @(negedge ref_clk_i);
    check(cmd_ready_o, 1'b0, "refused");
    cmd_valid_i = 1'b0;
    rsp_ready_i = 1'b1;
    n = 0;
    repeat (6) begin
      if (rsp_valid_o === 1'b1) n++;
      @(negedge ref_clk_i);
    end
    check(n, 2, "drained responses");
    $display("test stall done");
    label_filter_enable_i = 1'b0;
    u_arx_tx_model.send(32'h0000_0011);
    check(empty_o, 1'b0, "loaded");
    check(eos_n, 9, "end of word");
    hard_clear_input_i = 1'b1;
    @(negedge ref_clk_i);
    hard_clear_input_i = 1'b0;
    repeat (5) @(negedge ref_clk_i);
    check({empty_o, data_ready_o, pin_o}, 3'h5, "hard clear");
    rx_flag_select_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    check(pin_o, 1'b0, "flag select full");
    $display("test hard clear done");
    finish_test();
  end
endmodule  // tb_arx_receiver
